// *** ecs_sequencer.sv ***
// EEPROM command sequencer with APB register window
`include "ecs_cfg.svh"
module ecs_sequencer import ecs_pkg::*; #(
  parameter int WORDS = `ECS_EE_WORDS,
  parameter int AW    = $clog2(`ECS_EE_WORDS)
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             command_complete_flag
);

  ecs_regs_t   r_r;
  ecs_regs_t   r_nxt;
  ecs_chk_t    chk;
  logic        mem_we;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [AW-1:0] mem_idx;
  logic        rd_corr;
  logic        rd_uncorr;
  logic        wr_acc;
  logic        rd_set;
  logic        launch;
  logic        last_word;
  logic [15:0] expect_w;

  // True for the four mapped word offsets
  function automatic logic is_reg(input logic [11:0] a);
    return (a == `ECS_OFF_PIDX) || (a == `ECS_OFF_PDATA) ||
           (a == `ECS_OFF_STAT) || (a == `ECS_OFF_CFG);
  endfunction

  // Register view of the status flags
  function automatic logic [31:0] stat_word(input ecs_stat_t s);
    logic [31:0] w;
    w = '0;
    w[`ECS_ST_CCF] = s.ccf;
    w[`ECS_ST_ACC] = s.access_error_flag;
    w[`ECS_ST_PV]  = s.protection_violation_flag;
    w[`ECS_ST_MG1] = s.mg1;
    w[`ECS_ST_MG0] = s.mg0;
    return w;
  endfunction

  // Reset image: flag set, commands allowed, nothing protected
  function automatic ecs_regs_t reset_image();
    ecs_regs_t v;
    v                  = '0;
    v.stat.ccf         = 1'b1;
    v.cfg.mode_ok      = `ECS_CFG_RST;
    v.cfg.prot_first   = `ECS_PFS_RST;
    return v;
  endfunction

  ecs_launch_check #(
    .WORDS (WORDS)
  ) ecs_launch_check_inst (
    .words (r_r.words),
    .pidx  (r_r.pidx),
    .cfg   (r_r.cfg),
    .chk   (chk)
  );

  ecs_ee_array #(
    .WORDS (WORDS),
    .AW    (AW)
  ) ecs_ee_array_inst (
    .clk       (clk),
    .wr_en     (mem_we),
    .wr_idx    (mem_idx),
    .wr_data   (mem_wdata),
    .rd_idx    (mem_idx),
    .inject    (r_r.cfg.inject),
    .rd_data   (mem_rdata),
    .rd_corr   (rd_corr),
    .rd_uncorr (rd_uncorr)
  );

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_reg(paddr);
  assign prdata  = r_r.prdata;
  assign command_complete_flag = r_r.stat.ccf;

  // Bus phases: read data is captured in setup, writes land in access
  assign wr_acc = psel && penable && pwrite && is_reg(paddr);
  assign rd_set = psel && !penable && !pwrite;

  // A launch is refused while an earlier error is still flagged
  assign launch = wr_acc && (paddr == `ECS_OFF_STAT) &&
                  pwdata[`ECS_ST_CCF] && r_r.stat.ccf &&
                  !r_r.stat.access_error_flag && !r_r.stat.protection_violation_flag &&
                  !pwdata[`ECS_ST_ACC] && !pwdata[`ECS_ST_PV];

  // Memory port follows the job pointer
  assign mem_idx   = AW'(r_r.job.idx + r_r.ofs);
  assign last_word = (r_r.ofs + 16'd1) >= r_r.job.cnt;
  assign expect_w  = (r_r.st == ECS_PVF) ? r_r.words[2 + r_r.ofs[1:0]]
                                        : `ECS_ERASED;

  // Array writes: programming only clears bits and erase sets them all, so a second program of a
  // written word merges, and miscompares in the read-back where it asks for a bit already cleared
  always_comb begin
    mem_we    = 1'b0;
    mem_wdata = `ECS_ERASED;
    unique case (r_r.st)
      ECS_PGM: begin
        mem_we    = 1'b1;
        mem_wdata = mem_rdata & r_r.words[2 + r_r.ofs[1:0]];
      end
      ECS_ERS: begin
        mem_we    = 1'b1;
        mem_wdata = `ECS_ERASED;
      end
      default: begin
        mem_we    = 1'b0;
      end
    endcase
  end

  // Next state of all registers
  always_comb begin
    r_nxt = r_r;

    // Read data is captured during setup
    if (rd_set) begin
      unique case (paddr)
        `ECS_OFF_PIDX:  r_nxt.prdata = {29'h0, r_r.pidx};
        `ECS_OFF_PDATA: r_nxt.prdata = {16'h0, r_r.words[r_r.pidx]};
        `ECS_OFF_STAT:  r_nxt.prdata = stat_word(r_r.stat);
        `ECS_OFF_CFG:   r_nxt.prdata = {14'h0, r_r.cfg.inject,
                                        r_r.cfg.prot_first, 6'h0,
                                        r_r.cfg.prot_en,
                                        r_r.cfg.mode_ok};
        default:        r_nxt.prdata = 32'h0;
      endcase
    end

    // Software writes; parameters and setup are frozen while busy
    if (wr_acc) begin
      unique case (paddr)
        `ECS_OFF_PIDX: begin
          if (r_r.stat.ccf) begin
            r_nxt.pidx = pwdata[2:0];
          end
        end
        `ECS_OFF_PDATA: begin
          if (r_r.stat.ccf && (r_r.pidx <= 3'd5)) begin
            r_nxt.words[r_r.pidx] = pwdata[15:0];
          end
        end
        `ECS_OFF_STAT: begin
          if (pwdata[`ECS_ST_ACC]) begin
            r_nxt.stat.access_error_flag = 1'b0;
          end
          if (pwdata[`ECS_ST_PV]) begin
            r_nxt.stat.protection_violation_flag = 1'b0;
          end
        end
        `ECS_OFF_CFG: begin
          if (r_r.stat.ccf) begin
            r_nxt.cfg.mode_ok    = pwdata[`ECS_CF_MODE];
            r_nxt.cfg.prot_en    = pwdata[`ECS_CF_PEN];
            r_nxt.cfg.prot_first = pwdata[`ECS_CF_PFS_LO +: 8];
            r_nxt.cfg.inject     = pwdata[`ECS_CF_INJ_LO +: 2];
          end
        end
        default: begin
          r_nxt.cfg = r_r.cfg;
        end
      endcase
    end

    // Sequencer; hardware sets come after the software clears
    unique case (r_r.st)
      ECS_IDLE: begin
        if (launch) begin
          r_nxt.stat.ccf = 1'b0;
          r_nxt.stat.mg1 = 1'b0;
          r_nxt.stat.mg0 = 1'b0;
          r_nxt.st       = ECS_CHK;
        end
      end
      ECS_CHK: begin
        r_nxt.job = chk;
        r_nxt.ofs = 16'h0;
        if (chk.access_error_flag || chk.protection_violation_flag) begin
          r_nxt.stat.access_error_flag = r_nxt.stat.access_error_flag | chk.access_error_flag;
          r_nxt.stat.protection_violation_flag = r_nxt.stat.protection_violation_flag | chk.protection_violation_flag;
          r_nxt.stat.ccf    = 1'b1;
          r_nxt.st          = ECS_IDLE;
        end else if (chk.op == ECS_EVS && chk.cnt == 16'h0) begin
          // Empty section is trivially blank
          r_nxt.stat.ccf = 1'b1;
          r_nxt.st       = ECS_IDLE;
        end else begin
          r_nxt.st = chk.op;
        end
      end
      ECS_PGM, ECS_ERS: begin
        r_nxt.ofs = r_r.ofs + 16'd1;
        if (last_word) begin
          r_nxt.ofs = 16'h0;
          r_nxt.st  = (r_r.st == ECS_PGM) ? ECS_PVF : ECS_EVF;
        end
      end
      ECS_EVS, ECS_PVF, ECS_EVF: begin
        // Read-back: mismatch fails both bits, read errors by class
        if (mem_rdata != expect_w) begin
          r_nxt.stat.mg1 = 1'b1;
          r_nxt.stat.mg0 = 1'b1;
        end
        if (rd_corr || rd_uncorr) begin
          r_nxt.stat.mg1 = 1'b1;
        end
        if (rd_uncorr) begin
          r_nxt.stat.mg0 = 1'b1;
        end
        r_nxt.ofs = r_r.ofs + 16'd1;
        if (last_word) begin
          r_nxt.stat.ccf = 1'b1;
          r_nxt.st       = ECS_IDLE;
        end
      end
      default: begin
        r_nxt.st = ECS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= reset_image();
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule

// *** ecs_cfg.svh ***
// Register offsets, field positions, codes and reset values of the sequencer
`ifndef ECS_CFG_SVH
`define ECS_CFG_SVH

// Register byte offsets on the APB window
`define ECS_OFF_PIDX    12'h000
`define ECS_OFF_PDATA   12'h004
`define ECS_OFF_STAT    12'h008
`define ECS_OFF_CFG     12'h00c

// Command codes in the upper byte of the first parameter word
`define ECS_CMD_EVS     8'h10
`define ECS_CMD_PGM     8'h11
`define ECS_CMD_ERS     8'h12

// Parameter index values demanded at launch
`define ECS_IDX_EVS     3'b010
`define ECS_IDX_PGM_MIN 3'b010
`define ECS_IDX_PGM_MAX 3'b101
`define ECS_IDX_ERS     3'b001

// Status register bit positions
`define ECS_ST_CCF      7
`define ECS_ST_ACC      5
`define ECS_ST_PV       4
`define ECS_ST_MG1      1
`define ECS_ST_MG0      0

// Configuration register field positions
`define ECS_CF_MODE     0
`define ECS_CF_PEN      1
`define ECS_CF_PFS_LO   8
`define ECS_CF_INJ_LO   16

// Memory geometry and contents
`define ECS_EE_BASE     24'h10_0000
`define ECS_EE_WORDS    2048
`define ECS_SEC_SHIFT   1
`define ECS_ERASED      16'hffff

// Reset values
`define ECS_CFG_RST     1'b1
`define ECS_PFS_RST     8'hff

`endif

// *** ecs_pkg.sv ***
// Types shared by the command sequencer and its helpers
package ecs_pkg;

  // Sequencer states; one-bit steps IDLE to CHK to EVS, PGM to PVF and ERS to EVF
  typedef enum logic [2:0] {
    ECS_IDLE = 3'b000,
    ECS_CHK  = 3'b001,
    ECS_EVS  = 3'b011,
    ECS_PGM  = 3'b010,
    ECS_PVF  = 3'b110,
    ECS_ERS  = 3'b111,
    ECS_EVF  = 3'b101
  } ecs_state_t;

  typedef struct packed {
    logic [1:0] inject;      // Bit 1 uncorrectable, bit 0 correctable read
    logic [7:0] prot_first;  // First protected sector
    logic       prot_en;
    logic       mode_ok;
  } ecs_cfg_t;

  typedef struct packed {
    logic ccf;
    logic access_error_flag;
    logic protection_violation_flag;
    logic mg1;
    logic mg0;
  } ecs_stat_t;

  // Outcome of the launch checks
  typedef struct packed {
    logic       access_error_flag;
    logic       protection_violation_flag;
    ecs_state_t op;
    logic [15:0] idx;
    logic [15:0] cnt;
  } ecs_chk_t;

  typedef struct packed {
    ecs_state_t     st;
    ecs_stat_t      stat;
    ecs_cfg_t       cfg;
    logic [2:0]     pidx;
    logic [5:0][15:0] words;
    ecs_chk_t       job;
    logic [15:0]    ofs;
    logic [31:0]    prdata;
  } ecs_regs_t;

endpackage

// *** ecs_ee_array.sv ***
// EEPROM word array with one write port and one read port
`include "ecs_cfg.svh"
module ecs_ee_array import ecs_pkg::*; #(
  parameter int WORDS = `ECS_EE_WORDS,
  parameter int AW    = $clog2(`ECS_EE_WORDS)
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_idx,
  input  wire logic [1:0]    inject,
  output logic [15:0]        rd_data,
  output logic               rd_corr,
  output logic               rd_uncorr
);

  logic [15:0] mem [WORDS];

  // Cells leave the factory erased
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = `ECS_ERASED;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Error flags come from the inject field, since no ECC is modelled
  assign rd_data   = mem[rd_idx];
  assign rd_corr   = inject[0];
  assign rd_uncorr = inject[1];

endmodule

// *** ecs_launch_check.sv ***
// Launch checks: decode, alignment, range, index and protection
`include "ecs_cfg.svh"
module ecs_launch_check import ecs_pkg::*; #(
  parameter int WORDS = `ECS_EE_WORDS
) (
  input  wire logic [5:0][15:0] words,
  input  wire logic [2:0]       pidx,
  input  ecs_cfg_t              cfg,
  output ecs_chk_t              chk
);

  logic [23:0] addr;
  logic [23:0] off;
  logic [16:0] last;
  logic        bad;

  always_comb begin
    addr = {words[0][7:0], words[1]};
    off  = addr - `ECS_EE_BASE;
    chk  = '0;
    bad  = 1'b0;
    chk.idx = off[16:1];
    unique case (words[0][15:8])
      `ECS_CMD_EVS: begin
        chk.op  = ECS_EVS;
        chk.cnt = words[2];
        bad     = (pidx != `ECS_IDX_EVS);
      end
      `ECS_CMD_PGM: begin
        chk.op  = ECS_PGM;
        chk.cnt = 16'(pidx - 3'd1);
        bad     = (pidx < `ECS_IDX_PGM_MIN) ||
                  (pidx > `ECS_IDX_PGM_MAX);
      end
      `ECS_CMD_ERS: begin
        chk.op  = ECS_ERS;
        chk.idx = (off[16:1] >> `ECS_SEC_SHIFT) << `ECS_SEC_SHIFT;
        chk.cnt = 16'(1 << `ECS_SEC_SHIFT);
        bad     = (pidx != `ECS_IDX_ERS);
      end
      default: begin
        chk.op  = ECS_IDLE;
        bad     = 1'b1;
      end
    endcase
    // Section or group must end inside the block
    last = {1'b0, chk.idx} + {1'b0, chk.cnt};
    bad  = bad || (last > 17'(WORDS));
    bad  = bad || !cfg.mode_ok
               || (addr < `ECS_EE_BASE)
               || (off >= 24'(2 * WORDS))
               || addr[0];
    chk.access_error_flag = bad;
    // Protection only matters for a launch that is otherwise legal
    chk.protection_violation_flag = !bad && cfg.prot_en && (chk.op != ECS_EVS) &&
                 (8'((last - 17'd1) >> `ECS_SEC_SHIFT) >=
                  cfg.prot_first);
  end

endmodule

// *** ecs_sequencer_props.sv ***
// Bus and completion-flag checker bound to the command sequencer
`include "ecs_cfg.svh"
module ecs_sequencer_props import ecs_pkg::*; #(
  parameter int WORDS = `ECS_EE_WORDS
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        command_complete_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  localparam int LIMIT = WORDS + 8;
  logic        acc;
  logic        mapped;
  logic        ccf;
  logic [15:0] low_r;
  logic [15:0] low_nxt;

  // Access phase and the four mapped words
  assign acc = psel && penable;
  assign mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00;
  assign ccf = command_complete_flag;

  // Busy cycles; a hung command cannot hide from a bounded count
  assign low_nxt = ccf ? 16'h0000 : low_r + 16'h0001;
  always_ff @(posedge clk) begin
    if (reset)
      low_r <= 16'h0000;
    else
      low_r <= low_nxt;
  end

  a_flag_launch: assert property (
    $fell(ccf) |-> $past(acc && pwrite && paddr == `ECS_OFF_STAT
      && pwdata[`ECS_ST_CCF]))
    else $error("flag fell without launch");
  // A refused launch still spends its one check cycle with the flag low
  a_flag_min_low: assert property ($rose(ccf) |-> low_r != 16'h0000)
    else $error("flag rose too soon");
  a_busy_bounded: assert property (low_r <= LIMIT)
    else $error("command never completed");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  a_stat_flag: assert property (
    acc && !pwrite && paddr == `ECS_OFF_STAT |->
      prdata[`ECS_ST_CCF] == $past(ccf) && prdata[31:8] == 24'h000000)
    else $error("status read disagrees with flag");
  a_unmapped_zero: assert property (
    acc && !pwrite && !mapped |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_reset_idle: assert property (
    disable iff (1'b0) reset |=> ccf && prdata == 32'h00000000)
    else $error("reset state wrong");

  c_launch: cover property ($fell(ccf));
  c_unmapped: cover property (acc && !mapped);
  c_long_run: cover property (low_r == 16'h000a);
endmodule

bind ecs_sequencer ecs_sequencer_props #(.WORDS(WORDS)) ecs_props_inst (
  .clk                   (clk),
  .reset                 (reset),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .prdata                (prdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .command_complete_flag (command_complete_flag)
);

// *** ecs_sequencer_test.sv ***
// Self-checking bench of the EEPROM command sequencer
`include "ecs_cfg.svh"
module ecs_sequencer_test import ecs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        command_complete_flag;
  int          fail_count = 0;
  int          check_count = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ecs_sequencer ecs_sequencer_inst (
    .clk                   (clk),
    .reset                 (reset),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .command_complete_flag (command_complete_flag)
  );

  task automatic results();
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fail_count++;
      results();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h00000000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, !(a[11:4] == 8'h00 && a[1:0] == 2'b00)});
  endtask

  // Load words, launch, time completion in cycles and check status
  task automatic cmd(input logic [15:0] w0, input logic [15:0] w1,
                     input logic [63:0] dat, input logic [2:0] px,
                     input logic [7:0] st, input int cyc);
    logic [95:0] all;
    int          n;
    all = {dat, w1, w0};
    for (int i = 0; i <= int'(px) && i < 6; i++) begin
      wr(`ECS_OFF_PIDX, 32'(i));
      wr(`ECS_OFF_PDATA, {16'h0000, all[16*i +: 16]});
    end
    wr(`ECS_OFF_PIDX, {29'h0, px});
    wr(`ECS_OFF_STAT, 32'h00000080);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (command_complete_flag !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      results();
    end
    chk(32'(n), 32'(cyc));
    rdchk(`ECS_OFF_STAT, {24'h0, st});
    wr(`ECS_OFF_STAT, 32'h00000030);
  endtask

  task automatic t_reset();
    rdchk(`ECS_OFF_STAT, 32'h00000080);
    rdchk(`ECS_OFF_PIDX, 32'h00000000);
    rdchk(`ECS_OFF_CFG, 32'h0000ff01);
    rdchk(12'h010, 32'h00000000);
  endtask

  task automatic t_ops();
    // Counts run from the launch edge: check cycle, one per word (twice over for program and erase), then the cycle the flag is seen high
    cmd(16'h1010, 16'h0000, 64'h4, 3'd2, 8'h80, 6);
    cmd(16'h1010, 16'h0000, 64'h0, 3'd2, 8'h80, 2);
    // Targets are still erased, so no cumulative programming
    cmd(16'h1110, 16'h0010, 64'h1234, 3'd3, 8'h80, 6);
    cmd(16'h1010, 16'h0010, 64'h2, 3'd2, 8'h83, 4);
    cmd(16'h1210, 16'h0012, 64'h0, 3'd1, 8'h80, 6);
    cmd(16'h1010, 16'h0010, 64'h2, 3'd2, 8'h80, 4);
    cmd(16'h1110, 16'h0020, 64'h0, 3'd5, 8'h80, 10);
    cmd(16'h1010, 16'h0026, 64'h1, 3'd2, 8'h83, 3);
    cmd(16'h1010, 16'h0028, 64'h1, 3'd2, 8'h80, 3);
  endtask

  // Every launch fault completes at once with only the error flag
  task automatic t_errs();
    cmd(16'h1010, 16'h0000, 64'h1, 3'd1, 8'ha0, 2);
    cmd(16'h1110, 16'h0040, 64'h0, 3'd1, 8'ha0, 2);
    cmd(16'h1110, 16'h0040, 64'h0, 3'd6, 8'ha0, 2);
    cmd(16'h1210, 16'h0040, 64'h0, 3'd2, 8'ha0, 2);
    cmd(16'h1010, 16'h0041, 64'h1, 3'd2, 8'ha0, 2);
    cmd(16'h1110, 16'h0041, 64'h0, 3'd3, 8'ha0, 2);
    cmd(16'h1210, 16'h0041, 64'h0, 3'd1, 8'ha0, 2);
    cmd(16'h1020, 16'h0000, 64'h1, 3'd2, 8'ha0, 2);
    cmd(16'h1010, 16'h0ffe, 64'h2, 3'd2, 8'ha0, 2);
    cmd(16'h1010, 16'h0ffe, 64'h1, 3'd2, 8'h80, 3);
    cmd(16'h1110, 16'h0ffe, 64'h0, 3'd3, 8'ha0, 2);
    cmd(16'h1110, 16'h0ffc, 64'hffffffff, 3'd3, 8'h80, 6);
  endtask

  // Mode, protection and injected read errors
  task automatic t_cfg();
    wr(`ECS_OFF_CFG, 32'h0000ff00);
    cmd(16'h1010, 16'h0000, 64'h1, 3'd2, 8'ha0, 2);
    wr(`ECS_OFF_CFG, 32'h00000003);
    cmd(16'h1110, 16'h0030, 64'h0, 3'd2, 8'h90, 2);
    cmd(16'h1210, 16'h0020, 64'h0, 3'd1, 8'h90, 2);
    wr(`ECS_OFF_CFG, 32'h0001ff01);
    cmd(16'h1010, 16'h0030, 64'h1, 3'd2, 8'h82, 3);
    cmd(16'h1010, 16'h0020, 64'h1, 3'd2, 8'h83, 3);
    wr(`ECS_OFF_CFG, 32'h0002ff01);
    cmd(16'h1010, 16'h0040, 64'h1, 3'd2, 8'h83, 3);
    cmd(16'h1110, 16'h0040, 64'h5555, 3'd2, 8'h83, 4);
    wr(`ECS_OFF_CFG, 32'h0001ff01);
    cmd(16'h1210, 16'h0040, 64'h0, 3'd1, 8'h82, 6);
    wr(`ECS_OFF_CFG, 32'h0000ff01);
    cmd(16'h1010, 16'h0040, 64'h2, 3'd2, 8'h80, 4);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ops();
    t_errs();
    t_cfg();
    results();
  end
endmodule
